// ==== adc_input_mode_and_offset_control_bench.sv ====
`timescale 1ns/100ps
module adc_input_mode_and_offset_control_bench;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        CONV_START = 1'b0;
  logic        CAL_TRIG = 1'b0;
  logic        ERR_CLEAR = 1'b0;
  logic        CLK_EN = 1'b1;
  logic [11:0] ADC_RAW = 12'h010;
  logic [1:0]  w_cfg = 2'h0;
  logic [2:0]  w_mode = 3'h0;
  logic [1:0]  w_en = 2'h1;
  logic        obey = 1'b1;
  logic [1:0]  cfg, en, cap1, cap2;
  logic [2:0]  mode;
  logic        sw, busy, err, auton, hp, rv, rch;
  logic [11:0] res;
  int          mismatches = 0;
  int          total_checks = 0;
  // ----------------------------------------
  // Clock, host model and device
  // ----------------------------------------
  always #10 CLK = ~CLK;
  adcim_host host_u (.clk(CLK), .want_cfg(w_cfg), .want_mode(w_mode), .want_en(w_en), .obey(obey),
                     .cfg(cfg), .mode(mode), .en(en));
  adcim_top #(.CAL_CYCLES(4)) dut_u (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .INPUT_CONFIG_FIELD(cfg),
    .OPERATING_MODE_CODE(mode), .SEQUENCE_CHANNEL_ENABLES(en), .CALIBRATION_TRIGGER_BIT(CAL_TRIG),
    .CONV_START(CONV_START), .ERR_CLEAR(ERR_CLEAR), .ADC_RAW(ADC_RAW), .CAP1_SRC(cap1), .CAP2_SRC(cap2),
    .SAMPLE_SW_CLOSED(sw), .BUSY(busy), .SEQ_ERROR(err), .AUTONOMOUS(auton), .HIGH_PRECISION(hp),
    .RESULT_VALID(rv), .RESULT_CH(rch), .RESULT(res));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle();
    for (int i = 0; i < 60 && busy !== 1'b0; i++) tick(1);
    chk({11'h0, busy}, 12'h0);
  endtask
  task automatic pulse_start();
    @(posedge CLK) CONV_START <= 1'b1;
    @(posedge CLK) CONV_START <= 1'b0;
  endtask
  // Waits for one result and judges its value and channel
  task automatic take(input logic [11:0] exp, input logic ch);
    for (int i = 0; i < 20 && rv !== 1'b1; i++) tick(1);
    chk({11'h0, rv}, 12'h1);
    chk(res, exp);
    chk({11'h0, rch}, {11'h0, ch});
    tick(1);
  endtask
  task automatic setup(input logic [1:0] c, input logic [2:0] m, input logic [1:0] e);
    @(posedge CLK)
    begin
      w_cfg  <= c;
      w_mode <= m;
      w_en   <= e;
    end
    tick(3);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    tick(2);
    chk({11'h0, busy}, 12'h1);
    chk({11'h0, sw}, 12'h0);
    idle();
    chk({11'h0, sw}, 12'h1);
    chk({10'h0, cap1}, {10'h0, adcim_pkg::SRC_IN0});
    chk({10'h0, cap2}, {10'h0, adcim_pkg::SRC_GND});
    $display("test reset done");
  endtask
  task automatic t_mux();
    for (int c = 0; c < 4; c++)
    begin
      setup(c[1:0], 3'h0, 2'h1);
      chk({10'h0, cap1}, {10'h0, adcim_pkg::SRC_IN0});
      chk({10'h0, cap2}, (c == 1 || c == 2) ? {10'h0, adcim_pkg::SRC_IN1} : {10'h0, adcim_pkg::SRC_GND});
    end
    $display("test mux done");
  endtask
  task automatic t_manual();
    for (int m = 0; m < 2; m++)
    begin
      setup(2'h0, m[2:0], 2'h3);
      @(posedge CLK) ADC_RAW <= 12'h123;
      pulse_start();
      take(12'h113, 1'b0);
      idle();
    end
    @(posedge CLK) ADC_RAW <= 12'h008;
    pulse_start();
    take(12'h000, 1'b0);
    $display("test manual done");
  endtask
  task automatic t_seq();
    setup(2'h0, 3'h4, 2'h3);
    @(posedge CLK) ADC_RAW <= 12'h200;
    pulse_start();
    tick(1);
    chk({11'h0, busy}, 12'h1);
    take(12'h1f0, 1'b0);
    chk({10'h0, cap1}, {10'h0, adcim_pkg::SRC_IN1});
    take(12'h1f0, 1'b1);
    idle();
    setup(2'h0, 3'h5, 2'h2);
    pulse_start();
    take(12'h1f0, 1'b1);
    idle();
    for (int m = 4; m < 8; m++)
    begin
      setup(2'h0, m[2:0], 2'h1);
      chk({10'h0, auton, hp}, (m == 6) ? 12'h2 : (m == 7) ? 12'h1 : 12'h0);
    end
    setup(2'h0, 3'h0, 2'h1);
    idle();
    $display("test sequence done");
  endtask
  task automatic t_err();
    @(posedge CLK) obey <= 1'b0;
    setup(2'h1, 3'h4, 2'h3);
    chk({11'h0, err}, 12'h1);
    @(posedge CLK) obey <= 1'b1;
    setup(2'h2, 3'h4, 2'h3);
    chk({11'h0, err}, 12'h1);
    @(posedge CLK) ERR_CLEAR <= 1'b1;
    @(posedge CLK) ERR_CLEAR <= 1'b0;
    tick(2);
    chk({11'h0, err}, 12'h0);
    setup(2'h0, 3'h0, 2'h1);
    $display("test error done");
  endtask
  task automatic t_cal();
    @(posedge CLK) ADC_RAW <= 12'h020;
    @(posedge CLK) CAL_TRIG <= 1'b1;
    @(posedge CLK) CAL_TRIG <= 1'b0;
    tick(1);
    chk({10'h0, busy, sw}, 12'h2);
    // A frozen calibration must not finish on its own
    @(posedge CLK) CLK_EN <= 1'b0;
    tick(8);
    chk({11'h0, busy}, 12'h1);
    @(posedge CLK) CLK_EN <= 1'b1;
    idle();
    @(posedge CLK) ADC_RAW <= 12'h123;
    pulse_start();
    take(12'h103, 1'b0);
    $display("test calibration done");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_mux();
    t_manual();
    t_seq();
    t_err();
    t_cal();
    end_of_test();
  end
endmodule

// ==== adcim_corr.sv ====
`timescale 1ns/100ps
module adcim_corr #(
  parameter int W = 12
) (
  input  wire logic [W-1:0] raw,
  input  wire logic [W-1:0] offs,
  output logic      [W-1:0] code
);
  // Saturating offset removal keeps the result straight binary
  logic [W:0] diff;
  always_comb
  begin
    diff = {1'b0, raw} - {1'b0, offs};
    if (diff[W])
      code = adcim_pkg::NEG_FS_CODE;
    else
      code = diff[W-1:0];
  end
endmodule

// ==== adcim_host.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Host model: holds the configuration ports
// ----------------------------------------
// Updates are registered, so the bench lets a few cycles pass after a change.
module adcim_host (
  input  wire logic       clk,
  input  wire logic [1:0] want_cfg,
  input  wire logic [2:0] want_mode,
  input  wire logic [1:0] want_en,
  input  wire logic       obey,
  output logic      [1:0] cfg,
  output logic      [2:0] mode,
  output logic      [1:0] en
);
  always_ff @(posedge clk)
  begin
    cfg  <= want_cfg;
    mode <= want_mode;
    // A careless host may leave channel 1 enabled; only a scenario asks for that
    en   <= (obey && (want_cfg == 2'h1 || want_cfg == 2'h2)) ? {1'b0, want_en[0]} : want_en;
  end
endmodule

// ==== adcim_pkg.sv ====
package adcim_pkg;
  // Input configuration field codes
  localparam logic [1:0] CFG_TWO_SE_A   = 2'h0;
  localparam logic [1:0] CFG_SE_GSENSE  = 2'h1;
  localparam logic [1:0] CFG_PSEUDO_DIF = 2'h2;
  localparam logic [1:0] CFG_TWO_SE_B   = 2'h3;
  localparam logic [1:0] CFG_RESET      = 2'h0;
  // Operating mode codes
  localparam logic [2:0] MODE_MAN_A     = 3'h0;
  localparam logic [2:0] MODE_MAN_B     = 3'h1;
  localparam logic [2:0] MODE_MAN_SEQ_A = 3'h4;
  localparam logic [2:0] MODE_MAN_SEQ_B = 3'h5;
  localparam logic [2:0] MODE_AUTO_SEQ  = 3'h6;
  localparam logic [2:0] MODE_HP_SEQ    = 3'h7;
  localparam logic [2:0] MODE_RESET     = 3'h0;
  localparam logic [1:0] CHEN_RESET     = 2'h1;
  // Capacitor source selects
  localparam logic [1:0] SRC_GND  = 2'h0;
  localparam logic [1:0] SRC_IN0  = 2'h1;
  localparam logic [1:0] SRC_IN1  = 2'h2;
  localparam int         RES_BITS = 12;
  localparam logic [11:0] NEG_FS_CODE = 12'h000;
  localparam logic [11:0] POS_FS_CODE = 12'hfff;
  // Calibration settle time: 1000 ns at 50 MHz
  localparam int CAL_NS    = 1000;
  localparam int CLK_MHZ   = 50;
  localparam int CAL_CYC   = (CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC  = 4;
endpackage

// ==== adcim_top.sv ====
`timescale 1ns/100ps
module adcim_top #(
  parameter int CAL_CYCLES = adcim_pkg::CAL_CYC,
  parameter int CONV_CYCLES = adcim_pkg::CONV_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic [1:0]  INPUT_CONFIG_FIELD,
  input  wire logic [2:0]  OPERATING_MODE_CODE,
  input  wire logic [1:0]  SEQUENCE_CHANNEL_ENABLES,
  input  wire logic        CALIBRATION_TRIGGER_BIT,
  input  wire logic        CONV_START,
  input  wire logic        ERR_CLEAR,
  input  wire logic [11:0] ADC_RAW,
  output logic      [1:0]  CAP1_SRC,
  output logic      [1:0]  CAP2_SRC,
  output logic             SAMPLE_SW_CLOSED,
  output logic             BUSY,
  output logic             SEQ_ERROR,
  output logic             AUTONOMOUS,
  output logic             HIGH_PRECISION,
  output logic             RESULT_VALID,
  output logic             RESULT_CH,
  output logic      [11:0] RESULT
);
  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_CAL  = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_CONV = 4'b0100,
    ST_NEXT = 4'b1000
  } adcim_st_t;

  typedef struct packed {
    adcim_st_t   st;
    logic [15:0] cnt;
    logic        ch;
    logic        seq_run;
    logic [11:0] offs;
    logic        err;
    logic        vld;
    logic        res_ch;
    logic [11:0] res;
  } adcim_state_t;

  adcim_state_t s_r;
  adcim_state_t s_nxt;
  logic [1:0]   rst_sync_r;
  logic         rst_n;
  logic         single_cfg;
  logic         seq_mode;
  logic [1:0]   chen_eff;
  logic [11:0]  corr_code;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Codes 01b and 10b are the single-channel configurations
  assign single_cfg = (INPUT_CONFIG_FIELD == adcim_pkg::CFG_SE_GSENSE) ||
                      (INPUT_CONFIG_FIELD == adcim_pkg::CFG_PSEUDO_DIF);
  // Top bit set selects sequencing; 000b/001b stay manual on channel 0
  assign seq_mode = OPERATING_MODE_CODE[2];
  // Channel 1 never converts in single-channel mode, only flags
  assign chen_eff = {SEQUENCE_CHANNEL_ENABLES[1] & ~single_cfg, SEQUENCE_CHANNEL_ENABLES[0]};

  adcim_corr #(
    .W (adcim_pkg::RES_BITS)
  ) u_corr (
    .raw  (ADC_RAW),
    .offs (s_r.offs),
    .code (corr_code)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.vld = 1'b0;
    // Error flag: set wins over clear
    if (ERR_CLEAR)
      s_nxt.err = 1'b0;
    if (seq_mode && single_cfg && SEQUENCE_CHANNEL_ENABLES[1])
      s_nxt.err = 1'b1;
    unique case (s_r.st)
      ST_CAL:
      begin
        // Switches open while the offset is measured
        if (s_r.cnt >= 16'(CAL_CYCLES - 1))
        begin
          s_nxt.offs = ADC_RAW;
          s_nxt.cnt  = 16'h0000;
          s_nxt.st   = ST_IDLE;
        end
        else
          s_nxt.cnt = s_r.cnt + 16'h0001;
      end
      ST_IDLE:
      begin
        if (CALIBRATION_TRIGGER_BIT)
        begin
          s_nxt.st  = ST_CAL;
          s_nxt.cnt = 16'h0000;
        end
        else if (CONV_START || OPERATING_MODE_CODE == adcim_pkg::MODE_AUTO_SEQ ||
                 OPERATING_MODE_CODE == adcim_pkg::MODE_HP_SEQ)
        begin
          if (!seq_mode)
          begin
            s_nxt.ch      = 1'b0;
            s_nxt.seq_run = 1'b0;
            s_nxt.st      = ST_CONV;
          end
          else if (chen_eff != 2'h0)
          begin
            s_nxt.ch      = ~chen_eff[0]; // Channel 0 first
            s_nxt.seq_run = 1'b1;
            s_nxt.st      = ST_CONV;
          end
          s_nxt.cnt = 16'h0000;
        end
      end
      ST_CONV:
      begin
        if (s_r.cnt >= 16'(CONV_CYCLES - 1))
        begin
          s_nxt.res    = corr_code;
          s_nxt.res_ch = s_r.ch;
          s_nxt.vld    = 1'b1;
          s_nxt.cnt    = 16'h0000;
          s_nxt.st     = ST_NEXT;
        end
        else
          s_nxt.cnt = s_r.cnt + 16'h0001;
      end
      ST_NEXT:
      begin
        if (s_r.seq_run && !s_r.ch && chen_eff[1])
        begin
          s_nxt.ch = 1'b1;
          s_nxt.st = ST_CONV;
        end
        else
        begin
          s_nxt.seq_run = 1'b0;
          s_nxt.st      = ST_IDLE;
        end
      end
      default:
        s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r        <= '0;
      s_r.st     <= ST_CAL;
    end
    else if (CLK_EN)
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    if (single_cfg)
    begin
      CAP1_SRC = adcim_pkg::SRC_IN0;
      CAP2_SRC = adcim_pkg::SRC_IN1;
    end
    else
    begin
      CAP1_SRC = s_r.ch ? adcim_pkg::SRC_IN1 : adcim_pkg::SRC_IN0;
      CAP2_SRC = adcim_pkg::SRC_GND;
    end
  end
  assign SAMPLE_SW_CLOSED = (s_r.st == ST_IDLE);
  assign BUSY             = (s_r.st == ST_CAL) || s_r.seq_run;
  assign SEQ_ERROR        = s_r.err;
  assign AUTONOMOUS       = (OPERATING_MODE_CODE == adcim_pkg::MODE_AUTO_SEQ);
  assign HIGH_PRECISION   = (OPERATING_MODE_CODE == adcim_pkg::MODE_HP_SEQ);
  assign RESULT_VALID     = s_r.vld;
  assign RESULT_CH        = s_r.res_ch;
  assign RESULT           = s_r.res;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  cal_busy_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s_r.st == ST_CAL) |-> (BUSY && !SAMPLE_SW_CLOSED))
    else $error("busy low or switches closed in calibration");
  err_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (CLK_EN && seq_mode && single_cfg && SEQUENCE_CHANNEL_ENABLES[1]) |=> SEQ_ERROR)
    else $error("sequence error not flagged");
  cap2_gnd_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !single_cfg |-> (CAP2_SRC == adcim_pkg::SRC_GND))
    else $error("cap two not on ground");
  single_caps_a: assert property (@(posedge CLK) disable iff (!rst_n)
    single_cfg |-> (CAP1_SRC == adcim_pkg::SRC_IN0 && CAP2_SRC == adcim_pkg::SRC_IN1))
    else $error("single channel caps wrong");
  man_ch0_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s_r.st == ST_CONV && !s_r.seq_run) |-> !s_r.ch)
    else $error("manual mode converted channel 1");
  ch_order_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (RESULT_VALID && RESULT_CH && s_r.seq_run && chen_eff[0]) |-> $past(s_r.ch, 1 + CONV_CYCLES + 1) == 1'b0)
    else $error("channel 1 converted before channel 0");
  ch1_en_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s_r.st == ST_CONV && s_r.ch) |-> chen_eff[1])
    else $error("disabled channel converted");
  res_clip_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (CLK_EN && s_r.st == ST_CONV && ADC_RAW <= s_r.offs && s_r.cnt == 16'(CONV_CYCLES - 1))
    |=> RESULT == adcim_pkg::NEG_FS_CODE)
    else $error("under-range result not zero");
  cal_cov: cover property (@(posedge CLK) disable iff (!rst_n)
    (s_r.st == ST_CAL) ##1 (s_r.st == ST_IDLE));
  seq_cov: cover property (@(posedge CLK) disable iff (!rst_n)
    RESULT_VALID && RESULT_CH);
  err_cov: cover property (@(posedge CLK) disable iff (!rst_n) $rose(SEQ_ERROR));
endmodule
